//--- src/mmp_pkg.sv
package mmp_pkg;

  // ------------------------------------------------------------
  // Register window layout
  // ------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam logic [10:0] OFF_BLOCK_ID = 11'h000;
  localparam logic [10:0] OFF_IRQ_EVENTS = 11'h004;
  localparam logic [10:0] OFF_IRQ_ENABLES = 11'h008;
  localparam logic [10:0] OFF_RX_RING_UPD = 11'h010;
  localparam logic [10:0] OFF_TX_RING_UPD = 11'h014;
  localparam logic [10:0] OFF_ETH_CONTROL = 11'h024;
  localparam logic [10:0] OFF_MGMT_FRAME = 11'h040;
  localparam logic [10:0] OFF_MGMT_SPEED = 11'h044;
  localparam logic [10:0] OFF_COUNTER_CTRL = 11'h064;
  localparam logic [10:0] OFF_RX_CONTROL = 11'h084;
  localparam logic [10:0] OFF_RX_HASH = 11'h088;
  localparam logic [10:0] OFF_TX_CONTROL = 11'h0c4;
  localparam logic [10:0] OFF_STATION_LOW = 11'h0e4;
  localparam logic [10:0] OFF_STATION_HIGH = 11'h0e8;
  localparam logic [10:0] OFF_PAUSE = 11'h0ec;
  localparam logic [10:0] OFF_UC_HASH_UP = 11'h118;
  localparam logic [10:0] OFF_UC_HASH_LO = 11'h11c;
  localparam logic [10:0] OFF_MC_HASH_UP = 11'h120;
  localparam logic [10:0] OFF_MC_HASH_LO = 11'h124;
  localparam logic [10:0] OFF_FIFO_REV = 11'h140;
  localparam logic [10:0] OFF_TX_WMARK = 11'h144;
  localparam logic [10:0] OFF_FIFO_MEM_CTRL = 11'h180;
  localparam logic [10:0] OFF_RX_FIFO_DATA = 11'h184;
  localparam logic [10:0] OFF_RX_FIFO_STATE = 11'h188;
  localparam logic [10:0] OFF_RX_FIFO_CTRL = 11'h18c;
  localparam logic [10:0] OFF_RX_FIFO_LRF = 11'h190;
  localparam logic [10:0] OFF_RX_FIFO_LWF = 11'h194;
  // Window regions: 000-1FF control, 200-3FF counters, 400-7FF reserved
  localparam logic [1:0] REGION_CSR = 2'h0;
  localparam logic [1:0] REGION_STATS = 2'h1;
  localparam int WORD_LSB = 2;
  localparam int CSR_WORDS = 128;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int EVT_MGMT_DONE_BIT = 23;
  localparam int EVT_RX_ERR_BIT = 22;
  localparam int EVT_FALSE_CARR_BIT = 21;
  localparam int EVT_COLLISION_BIT = 20;
  localparam int TXC_FULL_DUPLEX_BIT = 2;
  localparam int SPEED_LSB = 1;
  localparam int SPEED_W = 6;
  localparam int SPEED_NO_PREAMBLE_BIT = 7;

  // ------------------------------------------------------------
  // Link codes
  // ------------------------------------------------------------
  localparam logic [3:0] RX_FALSE_CARRIER = 4'he;
  localparam logic [1:0] MGMT_START = 2'h1;
  localparam logic [1:0] MGMT_OP_READ = 2'h2;
  localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
  localparam logic [6:0] MGMT_PREAMBLE_BITS = 7'h20;
  localparam logic [6:0] MGMT_FRAME_BITS = 7'h20;
  localparam logic [6:0] MGMT_TA_DATA_BITS = 7'h12;
  localparam logic [6:0] MGMT_DATA_BITS = 7'h10;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MDC_MIN_HALF_NS = 160;
  localparam int MDC_MIN_PERIOD_NS = 400;
  localparam int MDC_HALF_CYC = (MDC_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MDC_PER_HALF_CYC = (MDC_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int MDC_MIN_CYC = (MDC_HALF_CYC > MDC_PER_HALF_CYC) ? MDC_HALF_CYC : MDC_PER_HALF_CYC;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] start;
    logic [1:0] op;
    logic [4:0] phyAddr;
    logic [4:0] regAddr;
    logic [1:0] turn;
    logic [15:0] data;
  } mmp_mgmt_frame_s;

  typedef struct packed {
    logic clk;
    logic dv;
    logic er;
    logic [3:0] data;
  } mmp_rx_pins_s;

  typedef enum logic [1:0] {
    MG_IDLE,
    MG_LOW,
    MG_HIGH
  } mmp_mgmt_state_e;

endpackage

//--- src/mmp_mii_port.sv
`timescale 1ns/1ns
module mmp_mii_port #(
  parameter logic [15:0] BLOCK_ID = 16'h00a5,      // Arbitrary value
  parameter logic [31:0] FIFO_REV_SIZE = 32'h0000_0001 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic regSel,
  input wire logic regWrite,
  input wire logic [10:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regAck,
  input wire logic txValid,
  input wire logic [3:0] txNibble,
  input wire logic txError,
  output logic txReady,
  output logic [3:0] rxNibble,
  output logic rxValid,
  output logic rxFrameError,
  output logic rxFrameEnd,
  output logic falseCarrier,
  output logic carrierSense,
  output logic collision,
  output logic mgmtBusy,
  input wire logic txClkPin,
  output logic txEnPin,
  output logic [3:0] txDataPin,
  output logic txErPin,
  input wire logic rxClkPin,
  input wire logic rxDvPin,
  input wire logic [3:0] rxDataPin,
  input wire logic rxErPin,
  input wire logic crsPin,
  input wire logic colPin,
  output logic mgmtClkPin,
  input wire logic mgmtDataIn,
  output logic mgmtDataOut,
  output logic mgmtDataOutEnable
);

  localparam int ASYNC_W = 11;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [ASYNC_W-1:0] asyncIn;
  logic [ASYNC_W-1:0] syncOneQ;
  logic [ASYNC_W-1:0] syncTwoQ;
  logic txClkLastQ;
  logic rxClkLastQ;
  logic txClkS;
  logic crsS;
  logic colS;
  logic mdiS;
  mmp_pkg::mmp_rx_pins_s rxS;

  assign asyncIn = {txClkPin, rxClkPin, rxDvPin, rxErPin, rxDataPin, crsPin, colPin, mgmtDataIn};
  assign {txClkS, rxS, crsS, colS, mdiS} = syncTwoQ;

  // Two-stage capture of every pin input
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncOneQ <= '0;
      syncTwoQ <= '0;
      txClkLastQ <= 1'b0;
      rxClkLastQ <= 1'b0;
    end else begin
      syncOneQ <= asyncIn;
      syncTwoQ <= syncOneQ;
      txClkLastQ <= txClkS;
      rxClkLastQ <= rxS.clk;
    end
  end

  // ------------------------------------------------------------
  // Register window decode
  // ------------------------------------------------------------
  logic [31:0] csrMem [mmp_pkg::CSR_WORDS];
  logic [31:0] irqEventsQ;
  logic [31:0] irqEventsD;
  logic [31:0] evtSet;
  mmp_pkg::mmp_mgmt_frame_s mgmtFrameQ;
  logic [31:0] mgmtSpeedQ;
  logic [31:0] rdMux;
  logic [31:0] regRdataQ;
  logic regAckQ;
  logic [6:0] wordIdx;
  logic inCsr;
  logic access;
  logic wrAccess;
  logic plainRw;
  logic hitEvents;
  logic hitMgmtFrame;
  logic hitMgmtSpeed;
  logic mgIdle;
  logic fullDuplex;

  // Region select and named-register hits
  assign access = regSel && !regAckQ;
  assign wrAccess = access && regWrite;
  assign inCsr = regAddr[10:9] == mmp_pkg::REGION_CSR;
  assign wordIdx = regAddr[8:mmp_pkg::WORD_LSB];
  assign hitEvents = inCsr && regAddr == mmp_pkg::OFF_IRQ_EVENTS;
  assign hitMgmtFrame = inCsr && regAddr == mmp_pkg::OFF_MGMT_FRAME;
  assign hitMgmtSpeed = inCsr && regAddr == mmp_pkg::OFF_MGMT_SPEED;
  assign fullDuplex = csrMem[mmp_pkg::OFF_TX_CONTROL[8:2]][mmp_pkg::TXC_FULL_DUPLEX_BIT];

  // Plain read/write storage words
  always_comb begin
    case (regAddr)
      mmp_pkg::OFF_IRQ_ENABLES, mmp_pkg::OFF_RX_RING_UPD, mmp_pkg::OFF_TX_RING_UPD,
      mmp_pkg::OFF_ETH_CONTROL, mmp_pkg::OFF_COUNTER_CTRL, mmp_pkg::OFF_RX_CONTROL,
      mmp_pkg::OFF_TX_CONTROL, mmp_pkg::OFF_STATION_LOW, mmp_pkg::OFF_STATION_HIGH,
      mmp_pkg::OFF_PAUSE, mmp_pkg::OFF_UC_HASH_UP, mmp_pkg::OFF_UC_HASH_LO,
      mmp_pkg::OFF_MC_HASH_UP, mmp_pkg::OFF_MC_HASH_LO, mmp_pkg::OFF_TX_WMARK,
      mmp_pkg::OFF_FIFO_MEM_CTRL, mmp_pkg::OFF_RX_FIFO_DATA, mmp_pkg::OFF_RX_FIFO_CTRL,
      mmp_pkg::OFF_RX_FIFO_LRF, mmp_pkg::OFF_RX_FIFO_LWF: plainRw = 1'b1;
      default: plainRw = 1'b0;
    endcase
  end

  // Read data select; counters and reserved space read zero
  always_comb begin
    if (!inCsr) begin
      rdMux = mmp_pkg::RESET_WORD;
    end else if (plainRw) begin
      rdMux = csrMem[wordIdx];
    end else begin
      case (regAddr)
        mmp_pkg::OFF_BLOCK_ID: rdMux = {BLOCK_ID, 16'h0000};
        mmp_pkg::OFF_IRQ_EVENTS: rdMux = irqEventsQ;
        mmp_pkg::OFF_MGMT_FRAME: rdMux = mgmtFrameQ;
        mmp_pkg::OFF_MGMT_SPEED: rdMux = mgmtSpeedQ;
        mmp_pkg::OFF_FIFO_REV: rdMux = FIFO_REV_SIZE;
        default: rdMux = mmp_pkg::RESET_WORD;
      endcase
    end
  end

  // Event bits: hardware set wins over a write-one clear
  assign irqEventsD = (irqEventsQ & ~((wrAccess && hitEvents) ? regWdata : 32'h0000_0000)) | evtSet;
  assign regRdata = regRdataQ;
  assign regAck = regAckQ;

  // Bus answer and register storage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regAckQ <= 1'b0;
      regRdataQ <= mmp_pkg::RESET_WORD;
      irqEventsQ <= mmp_pkg::RESET_WORD;
      mgmtSpeedQ <= mmp_pkg::RESET_WORD;
      for (int i = 0; i < mmp_pkg::CSR_WORDS; i++) begin
        csrMem[i] <= mmp_pkg::RESET_WORD;
      end
    end else begin
      regAckQ <= access;
      if (access && !regWrite) begin
        regRdataQ <= rdMux;
      end
      irqEventsQ <= irqEventsD;
      if (wrAccess && inCsr && plainRw) begin
        csrMem[wordIdx] <= regWdata;
      end
      if (wrAccess && hitMgmtSpeed) begin
        mgmtSpeedQ <= regWdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit path on the sampled transmit clock
  // ------------------------------------------------------------
  logic txRise;
  logic txEnQ;
  logic [3:0] txDataQ;
  logic txErQ;

  assign txRise = txClkS && !txClkLastQ;
  assign txReady = txRise;
  assign txEnPin = txEnQ;
  assign txDataPin = txDataQ;
  assign txErPin = txErQ;

  // Nibble launch once per transmit clock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txEnQ <= 1'b0;
      txDataQ <= 4'h0;
      txErQ <= 1'b0;
    end else if (txRise) begin
      txEnQ <= txValid;
      txDataQ <= txValid ? txNibble : 4'h0;
      txErQ <= txValid && txError;
    end
  end

  // ------------------------------------------------------------
  // Receive path on the sampled receive clock
  // ------------------------------------------------------------
  logic rxRise;
  logic rxDvLastQ;
  logic rxValidQ;
  logic [3:0] rxNibbleQ;
  logic rxFrameErrQ;
  logic rxFrameEndQ;
  logic falseCarrierQ;
  logic rxFalseCode;
  logic carrierQ;
  logic collisionQ;

  assign rxRise = rxS.clk && !rxClkLastQ;
  assign rxFalseCode = !rxS.dv && rxS.er && rxS.data == mmp_pkg::RX_FALSE_CARRIER;
  assign rxNibble = rxNibbleQ;
  assign rxValid = rxValidQ;
  assign rxFrameError = rxFrameErrQ;
  assign rxFrameEnd = rxFrameEndQ;
  assign falseCarrier = falseCarrierQ;
  assign carrierSense = carrierQ;
  assign collision = collisionQ;

  // Nibble capture, frame error and frame end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxDvLastQ <= 1'b0;
      rxValidQ <= 1'b0;
      rxNibbleQ <= 4'h0;
      rxFrameErrQ <= 1'b0;
      rxFrameEndQ <= 1'b0;
      falseCarrierQ <= 1'b0;
    end else begin
      rxValidQ <= rxRise && rxS.dv;
      rxFrameEndQ <= rxRise && rxDvLastQ && !rxS.dv;
      falseCarrierQ <= rxRise && rxFalseCode;
      if (rxRise) begin
        rxDvLastQ <= rxS.dv;
        if (rxS.dv) begin
          rxNibbleQ <= rxS.data;
          rxFrameErrQ <= (rxDvLastQ && rxFrameErrQ) || rxS.er;
        end
      end
    end
  end

  // Media status levels; collision masked in full duplex
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      carrierQ <= 1'b0;
      collisionQ <= 1'b0;
    end else begin
      carrierQ <= crsS;
      collisionQ <= colS && !fullDuplex;
    end
  end

  // ------------------------------------------------------------
  // Management frame engine
  // ------------------------------------------------------------
  mmp_pkg::mmp_mgmt_state_e mgStateQ;
  logic [5:0] mgCntQ;
  logic [6:0] mgBitsQ;
  logic [5:0] mgHalf;
  logic [5:0] speedField;
  logic [4:0] bitIdx;
  logic [31:0] frameBits;
  logic mgStart;
  logic mgRead;
  logic mgHalfDone;
  logic mgDoneQ;
  logic curBit;
  logic inPreamble;
  logic releasePin;
  logic mdcQ;
  logic mdoQ;
  logic mdoeQ;

  assign speedField = mgmtSpeedQ[mmp_pkg::SPEED_LSB +: mmp_pkg::SPEED_W];
  assign mgHalf = (speedField > 6'(mmp_pkg::MDC_MIN_CYC)) ? speedField : 6'(mmp_pkg::MDC_MIN_CYC);
  assign mgHalfDone = mgCntQ >= mgHalf - 6'h01;
  assign mgIdle = mgStateQ == mmp_pkg::MG_IDLE;
  assign mgStart = wrAccess && hitMgmtFrame && mgIdle;
  assign mgRead = mgmtFrameQ.op == mmp_pkg::MGMT_OP_READ;
  assign frameBits = mgmtFrameQ;
  assign inPreamble = mgBitsQ > mmp_pkg::MGMT_FRAME_BITS;
  assign bitIdx = 5'(mgBitsQ - 7'h01);
  assign curBit = inPreamble ? 1'b1 : frameBits[bitIdx];
  assign releasePin = mgRead && mgBitsQ <= mmp_pkg::MGMT_TA_DATA_BITS;
  assign mgmtBusy = !mgIdle;
  assign mgmtClkPin = mdcQ;
  assign mgmtDataOut = mdoQ;
  assign mgmtDataOutEnable = mdoeQ;
  assign evtSet = {8'h00, mgDoneQ, rxRise && rxS.dv && rxS.er, falseCarrierQ,
                   collisionQ, 20'h00000};

  // Shift out one bit per management clock, data changing while low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mgStateQ <= mmp_pkg::MG_IDLE;
      mgCntQ <= 6'h00;
      mgBitsQ <= 7'h00;
      mgmtFrameQ <= '0;
      mgDoneQ <= 1'b0;
      mdcQ <= 1'b0;
      mdoQ <= 1'b0;
      mdoeQ <= 1'b0;
    end else begin
      mgDoneQ <= 1'b0;
      case (mgStateQ)
        mmp_pkg::MG_IDLE: begin
          mdcQ <= 1'b0;
          mdoeQ <= 1'b0;
          mgCntQ <= 6'h00;
          if (mgStart) begin
            mgmtFrameQ <= regWdata;
            mgBitsQ <= mgmtSpeedQ[mmp_pkg::SPEED_NO_PREAMBLE_BIT] ? mmp_pkg::MGMT_FRAME_BITS
                       : mmp_pkg::MGMT_FRAME_BITS + mmp_pkg::MGMT_PREAMBLE_BITS;
            mgStateQ <= mmp_pkg::MG_LOW;
          end
        end
        mmp_pkg::MG_LOW: begin
          mdoQ <= curBit;
          mdoeQ <= !releasePin;
          mgCntQ <= mgHalfDone ? 6'h00 : mgCntQ + 6'h01;
          if (mgHalfDone) begin
            mdcQ <= 1'b1;
            mgStateQ <= mmp_pkg::MG_HIGH;
            if (mgRead && mgBitsQ <= mmp_pkg::MGMT_DATA_BITS) begin
              mgmtFrameQ.data[bitIdx[3:0]] <= mdiS;
            end
          end
        end
        mmp_pkg::MG_HIGH: begin
          mgCntQ <= mgHalfDone ? 6'h00 : mgCntQ + 6'h01;
          if (mgHalfDone) begin
            mdcQ <= 1'b0;
            mgBitsQ <= mgBitsQ - 7'h01;
            if (mgBitsQ == 7'h01) begin
              mdoeQ <= 1'b0;
              mgDoneQ <= 1'b1;
              mgStateQ <= mmp_pkg::MG_IDLE;
            end else begin
              mgStateQ <= mmp_pkg::MG_LOW;
            end
          end
        end
        default: begin
          mgStateQ <= mmp_pkg::MG_IDLE;
        end
      endcase
    end
  end

endmodule

//--- bench/mmp_mii_port_sva.sv
`timescale 1ns/1ns
module mmp_mii_port_sva (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic regSel,
  input wire logic regWrite,
  input wire logic [10:0] regAddr,
  input wire logic regAck,
  input wire logic txReady,
  input wire logic txValid,
  input wire logic [3:0] txNibble,
  input wire logic txError,
  input wire logic txEnPin,
  input wire logic [3:0] txDataPin,
  input wire logic txErPin,
  input wire logic crsPin,
  input wire logic carrierSense,
  input wire logic mgmtBusy,
  input wire logic mgmtClkPin,
  input wire logic mgmtDataOut,
  input wire logic mgmtDataOutEnable
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_ack; regSel && !regAck |=> regAck; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_txer; txErPin |-> txEnPin; endproperty
  a_txer: assert property (p_txer) else $error("tx error outside frame");
  property p_txen; txReady |=> txEnPin == $past(txValid); endproperty
  a_txen: assert property (p_txen) else $error("tx enable wrong");
  property p_txnib; txReady && txValid |=> txDataPin == $past(txNibble) && txErPin == $past(txError); endproperty
  a_txnib: assert property (p_txnib) else $error("tx nibble wrong");
  property p_mdchi; $rose(mgmtClkPin) |=> mgmtClkPin; endproperty
  a_mdchi: assert property (p_mdchi) else $error("mgmt clock high too short");
  property p_mdclo; $fell(mgmtClkPin) |=> !mgmtClkPin; endproperty
  a_mdclo: assert property (p_mdclo) else $error("mgmt clock low too short");
  property p_mdo; mgmtClkPin |-> $stable(mgmtDataOut) && $stable(mgmtDataOutEnable); endproperty
  a_mdo: assert property (p_mdo) else $error("mgmt data moved while clock high");
  property p_idle; !mgmtBusy && !$past(mgmtBusy) |-> !mgmtDataOutEnable; endproperty
  a_idle: assert property (p_idle) else $error("mgmt pin driven when idle");
  property p_start; regSel && !regAck && regWrite && regAddr == mmp_pkg::OFF_MGMT_FRAME && !mgmtBusy |=> mgmtBusy; endproperty
  a_start: assert property (p_start) else $error("mgmt frame not started");
  property p_crs2; $rose(crsPin) && !carrierSense |=> !carrierSense; endproperty
  a_crs2: assert property (p_crs2) else $error("carrier used unsynchronised");
  property p_crsup; crsPin [*6] |-> carrierSense; endproperty
  a_crsup: assert property (p_crsup) else $error("carrier not seen");
endmodule

bind mmp_mii_port mmp_mii_port_sva i_sva (.ref_clk, .reset_n, .regSel, .regWrite, .regAddr, .regAck, .txReady,
  .txValid, .txNibble, .txError, .txEnPin, .txDataPin, .txErPin, .crsPin, .carrierSense, .mgmtBusy, .mgmtClkPin,
  .mgmtDataOut, .mgmtDataOutEnable);

//--- bench/mmp_phy_model.sv
`timescale 1ns/1ns
module mmp_phy_model #(
  parameter logic [15:0] READ_DATA = 16'h9c41
) (
  output logic txClk,
  output logic rxClk,
  input wire logic txEn,
  input wire logic [3:0] txData,
  input wire logic txEr,
  output logic rxDv,
  output logic [3:0] rxData,
  output logic rxEr,
  output logic crs,
  output logic col,
  input wire logic mdc,
  input wire logic mdio,
  output logic phyOut,
  output logic phyEn
);
  logic [4:0] txQ[$];
  logic [31:0] sr, frame;
  logic rd;
  int cnt, pre, preLen;
  // ----------------------------------------
  // Network side
  // ----------------------------------------
  initial begin
    {txClk, rxClk, rxDv, rxEr, crs, col, phyEn, phyOut, rd} = '0;
    rxData = 4'h0;
    sr = '1;
    frame = '0;
    cnt = 0;
    pre = 0;
    preLen = 0;
  end
  // Free-running clocks, unrelated phases
  always #400 txClk = ~txClk;
  initial #137 forever #400 rxClk = ~rxClk;
  // Nibble capture at transmit clock rise
  always @(posedge txClk) if (txEn === 1'b1) txQ.push_back({txEr, txData});
  task automatic rxNib(input logic dv, input logic er, input logic [3:0] d);
    @(negedge rxClk);
    rxDv <= dv;
    rxEr <= er;
    rxData <= d;
  endtask
  task automatic rxFrame(input logic [31:0] nibs, input int errAt);
    for (int i = 0; i < 8; i++) rxNib(1'b1, errAt == i, nibs[4*i+:4]);
    rxNib(1'b0, 1'b0, ~nibs[31:28]);
    rxNib(1'b0, 1'b0, nibs[31:28]);
  endtask
  task automatic media(input logic c, input logic k);
    #37;
    crs = c;
    col = k;
  endtask
  // ----------------------------------------
  // Management slave
  // ----------------------------------------
  always @(posedge mdc) begin
    sr <= {sr[30:0], mdio};
    if (cnt == 0) begin
      pre <= mdio ? pre + 1 : pre;
      if (!sr[0] && mdio) begin
        cnt <= 2;
        preLen <= pre;
        pre <= 0;
      end
    end else begin
      cnt <= cnt + 1;
    end
    if (cnt == 13) rd <= ({sr[10], sr[9]} == 2'b10);
    if (cnt == 14 && rd) begin
      phyEn <= 1'b1;
      phyOut <= 1'b0;
    end
    if (cnt >= 15 && cnt <= 30 && rd) phyOut <= READ_DATA[30 - cnt];
    if (cnt == 31) begin
      phyEn <= 1'b0;
      rd <= 1'b0;
      cnt <= 0;
      sr <= '1;
      frame <= {sr[30:0], mdio};
    end
  end
endmodule

//--- bench/mmp_mii_port_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin badCount++; \
  $display("Error at %0t: got %h, expected %h", $time, a, e); end end
module mmp_mii_port_bench;
  localparam logic [15:0] ID_VAL = 16'h0123; // Arbitrary value
  localparam logic [31:0] REV_VAL = 32'h0000_0002; // Arbitrary value
  localparam logic [31:0] NIBS = 32'h83ad_5555;
  localparam logic [31:0] WR_FRAME = 32'h5aaa_c3a5;
  localparam logic [31:0] RD_FRAME = 32'h61fc_0000;
  localparam logic [31:0] EV_MG = 32'h1 << mmp_pkg::EVT_MGMT_DONE_BIT;
  localparam logic [31:0] EV_RX = 32'h1 << mmp_pkg::EVT_RX_ERR_BIT;
  localparam logic [31:0] EV_FC = 32'h1 << mmp_pkg::EVT_FALSE_CARR_BIT;
  localparam logic [31:0] EV_COL = 32'h1 << mmp_pkg::EVT_COLLISION_BIT;
  logic ref_clk, reset_n, regSel, regWrite, regAck, txValid, txError, txReady;
  logic [10:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [3:0] txNibble, rxNibble, txDataPin, rxDataPin;
  logic rxValid, rxFrameError, rxFrameEnd, falseCarrier, carrierSense, collision, mgmtBusy;
  logic txClkPin, txEnPin, txErPin, rxClkPin, rxDvPin, rxErPin, crsPin, colPin;
  logic mgmtClkPin, mgmtDataOut, mgmtDataOutEnable, phyOut, phyEn;
  wire logic mdioWire;
  logic [3:0] rxQ[$];
  logic [3:0] codes[4] = '{4'h5, 4'h0, 4'hf, 4'he};
  logic [10:0] rwOffs[15] = '{11'h008, 11'h010, 11'h014, 11'h024, 11'h064, 11'h084, 11'h0e4, 11'h0e8,
    11'h0ec, 11'h118, 11'h124, 11'h144, 11'h180, 11'h18c, 11'h194};
  logic [10:0] holes[6] = '{11'h00c, 11'h03c, 11'h200, 11'h3fc, 11'h400, 11'h7fc};
  int badCount, totalChecks, cycles, ends, falses;
  // ----------------------------------------
  // Structure
  // ----------------------------------------
  // Pulled-up management wire
  assign mdioWire = mgmtDataOutEnable ? mgmtDataOut : (phyEn ? phyOut : 1'b1);
  mmp_mii_port #(.BLOCK_ID(ID_VAL), .FIFO_REV_SIZE(REV_VAL)) i_dut (.ref_clk, .reset_n, .regSel, .regWrite,
    .regAddr, .regWdata, .regRdata, .regAck, .txValid, .txNibble, .txError, .txReady, .rxNibble, .rxValid,
    .rxFrameError, .rxFrameEnd, .falseCarrier, .carrierSense, .collision, .mgmtBusy, .txClkPin, .txEnPin,
    .txDataPin, .txErPin, .rxClkPin, .rxDvPin, .rxDataPin, .rxErPin, .crsPin, .colPin, .mgmtClkPin,
    .mgmtDataIn(mdioWire), .mgmtDataOut, .mgmtDataOutEnable);
  mmp_phy_model #(.READ_DATA(16'h9c41)) i_phy (.txClk(txClkPin), .rxClk(rxClkPin), .txEn(txEnPin),
    .txData(txDataPin), .txEr(txErPin), .rxDv(rxDvPin), .rxData(rxDataPin), .rxEr(rxErPin), .crs(crsPin),
    .col(colPin), .mdc(mgmtClkPin), .mdio(mdioWire), .phyOut, .phyEn);
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  // Receive monitor and run limit
  always @(posedge ref_clk) begin
    cycles++;
    if (rxValid === 1'b1) rxQ.push_back(rxNibble);
    if (rxFrameEnd === 1'b1) ends++;
    if (falseCarrier === 1'b1) falses++;
    if (cycles == 20000) begin
      badCount++;
      $display("Error at %0t: run limit reached", $time);
      stopTest();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stopTest();
    $display("Checks %0d, mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic regAcc(input logic wr, input logic [10:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    regSel <= 1'b1;
    regWrite <= wr;
    regAddr <= a;
    regWdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (regAck !== 1'b1 && n < 10);
    q = regRdata;
    regSel <= 1'b0;
    @(posedge ref_clk);
    `CHK(n < 10, 1'b1)
  endtask
  task automatic regWr(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] q;
    regAcc(1'b1, a, d, q);
  endtask
  task automatic regChk(input logic [10:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    regAcc(1'b0, a, 32'h0, q);
    `CHK(q & m, e)
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (mgmtBusy !== 1'b0 && n < 600);
    `CHK(n < 600, 1'b1)
  endtask
  task automatic txSend(input logic [31:0] nibs, input int errAt);
    int n;
    txValid <= 1'b1;
    txNibble <= nibs[3:0];
    txError <= (errAt == 0);
    for (int i = 0; i < 8; i++) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (txReady !== 1'b1 && n < 20);
      if (i < 7) begin
        txNibble <= nibs[4*(i+1)+:4];
        txError <= (errAt == i + 1);
      end
    end
    txValid <= 1'b0;
    txError <= 1'b1;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset_n, regSel, regWrite, txValid, txError} = '0;
    regAddr = '0;
    regWdata = '0;
    txNibble = '0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    regWr(mmp_pkg::OFF_BLOCK_ID, 32'h0);
    regChk(mmp_pkg::OFF_BLOCK_ID, 32'hffff_0000, {ID_VAL, 16'h0});
    regChk(mmp_pkg::OFF_FIFO_REV, '1, REV_VAL);
    foreach (rwOffs[i]) begin
      regChk(rwOffs[i], '1, mmp_pkg::RESET_WORD);
      regWr(rwOffs[i], {21'h1a5a5a, rwOffs[i]});
      regChk(rwOffs[i], '1, {21'h1a5a5a, rwOffs[i]});
    end
    foreach (holes[i]) begin
      regWr(holes[i], '1);
      regChk(holes[i], '1, 32'h0);
    end
    // Write frame with preamble, second request while busy
    regWr(mmp_pkg::OFF_MGMT_SPEED, 32'h0000_0006);
    regWr(mmp_pkg::OFF_MGMT_FRAME, WR_FRAME);
    regWr(mmp_pkg::OFF_MGMT_FRAME, 32'h6000_0000);
    waitIdle();
    `CHK(i_phy.frame, WR_FRAME)
    `CHK(i_phy.preLen, 32)
    repeat (10) @(posedge ref_clk);
    `CHK(mgmtBusy, 1'b0)
    regChk(mmp_pkg::OFF_IRQ_EVENTS, EV_MG, EV_MG);
    regWr(mmp_pkg::OFF_IRQ_EVENTS, EV_MG);
    regChk(mmp_pkg::OFF_IRQ_EVENTS, EV_MG, 32'h0);
    // Read frame, no preamble, shortest clock
    regWr(mmp_pkg::OFF_MGMT_SPEED, 32'h0000_0082);
    regWr(mmp_pkg::OFF_MGMT_FRAME, RD_FRAME);
    waitIdle();
    `CHK(i_phy.frame[31:18], RD_FRAME[31:18])
    `CHK(i_phy.preLen, 0)
    regChk(mmp_pkg::OFF_MGMT_FRAME, 32'h0000_ffff, 32'h0000_9c41);
    // Transmit frame with one error nibble
    txSend(NIBS, 5);
    repeat (24) @(posedge ref_clk);
    `CHK(i_phy.txQ.size(), 8)
    foreach (i_phy.txQ[i]) `CHK(i_phy.txQ[i], {i == 5, NIBS[4*i+:4]})
    `CHK(txEnPin, 1'b0)
    txError <= 1'b0;
    // Receive frames, bad then clean
    i_phy.rxFrame(NIBS, 6);
    repeat (8) @(posedge ref_clk);
    `CHK(rxQ.size(), 8)
    foreach (rxQ[i]) `CHK(rxQ[i], NIBS[4*i+:4])
    `CHK(ends, 1)
    `CHK(rxFrameError, 1'b1)
    regChk(mmp_pkg::OFF_IRQ_EVENTS, EV_RX, EV_RX);
    i_phy.rxFrame(NIBS, 9);
    repeat (8) @(posedge ref_clk);
    `CHK(rxFrameError, 1'b0)
    `CHK(ends, 2)
    foreach (codes[i]) i_phy.rxNib(1'b0, 1'b1, codes[i]);
    i_phy.rxNib(1'b0, 1'b0, 4'h1);
    repeat (8) @(posedge ref_clk);
    `CHK(falses, 1)
    `CHK(rxQ.size(), 16)
    regChk(mmp_pkg::OFF_IRQ_EVENTS, EV_FC, EV_FC);
    // Carrier and collision, half then full duplex
    i_phy.media(1'b1, 1'b1);
    repeat (8) @(posedge ref_clk);
    `CHK(carrierSense, 1'b1)
    `CHK(collision, 1'b1)
    regChk(mmp_pkg::OFF_IRQ_EVENTS, EV_COL, EV_COL);
    regWr(mmp_pkg::OFF_TX_CONTROL, 32'h1 << mmp_pkg::TXC_FULL_DUPLEX_BIT);
    repeat (4) @(posedge ref_clk);
    `CHK(collision, 1'b0)
    i_phy.media(1'b0, 1'b0);
    repeat (8) @(posedge ref_clk);
    `CHK(carrierSense, 1'b0)
    regWr(mmp_pkg::OFF_IRQ_EVENTS, '1);
    regChk(mmp_pkg::OFF_IRQ_EVENTS, EV_MG | EV_RX | EV_FC | EV_COL, 32'h0);
    stopTest();
  end
endmodule
